// *** pmx_pkg.sv ***
/*
  Shared constants, types and helpers for the port 0 / port 1 / port 2 pin multiplexer.
  Assumes one clock domain (mclk) and a simple write-strobe configuration port.
*/
package pmx_pkg;

  // Port widths
  localparam int P0_W = 7;
  localparam int P1_W = 8;
  localparam int P2_W = 8;
  localparam int CFG_W = 8;

  // Reset values: input direction, pull-up off, port mode, latch low
  localparam logic [P0_W-1:0] P0_DIR_RST = 7'h7F;
  localparam logic [P1_W-1:0] P1_DIR_RST = 8'hFF;
  localparam logic [P2_W-1:0] P2_DIR_RST = 8'hFF;
  localparam logic [P0_W-1:0] P0_ZERO = 7'h00;
  localparam logic [P1_W-1:0] P1_ZERO = 8'h00;
  localparam logic [P2_W-1:0] P2_ZERO = 8'h00;
  // Port 2 comes out of reset in analog input mode
  localparam logic [P2_W-1:0] P2_ANA_RST = 8'hFF;

  // Port 0 bit positions
  localparam int P0_TA_CC = 0;
  localparam int P0_TA_CAP = 1;
  localparam int P0_CSB_SO = 2;
  localparam int P0_CSB_SI = 3;
  localparam int P0_CSB_CLK = 4;
  localparam int P0_TB_CC = 5;
  localparam int P0_TB_CAP = 6;

  // Port 1 bit positions
  localparam int P1_CSA_CLK = 0;
  localparam int P1_CSA_SI = 1;
  localparam int P1_CSA_SO = 2;
  localparam int P1_UB_TX = 3;
  localparam int P1_UB_RX = 4;
  localparam int P1_T8H_A = 5;
  localparam int P1_IRQ = 6;
  localparam int P1_T8_A = 7;

  // Configuration register select codes
  typedef enum logic [3:0] {
    PMX_REG_P0_DIR = 4'h0,
    PMX_REG_P0_PULL = 4'h1,
    PMX_REG_P0_CTRL = 4'h2,
    PMX_REG_P0_OUT = 4'h3,
    PMX_REG_P1_DIR = 4'h4,
    PMX_REG_P1_PULL = 4'h5,
    PMX_REG_P1_CTRL = 4'h6,
    PMX_REG_P1_OUT = 4'h7,
    PMX_REG_P2_DIR = 4'h8,
    PMX_REG_P2_ANA = 4'h9,
    PMX_REG_P2_OUT = 4'hA,
    PMX_REG_IRQ_EDGE = 4'hB
  } pmx_reg_t;

  // Interrupt edge selection
  typedef enum logic [1:0] {
    PMX_EDGE_NONE = 2'h0,
    PMX_EDGE_RISE = 2'h1,
    PMX_EDGE_FALL = 2'h2,
    PMX_EDGE_BOTH = 2'h3
  } pmx_edge_t;

  // Outputs of the on-chip peripherals towards the pins
  typedef struct packed {
    logic timer_a_out;
    logic timer_b_out;
    logic timer8_a_out;
    logic timer8h_a_out;
    logic timer8h_b_out;
    logic csia_serial_out;
    logic csia_serial_clk;
    logic csib_serial_out;
    logic csib_serial_clk;
    logic uart_a_tx;
    logic uart_b_tx;
  } pmx_per_out_t;

  // Timer inputs taken from the pins
  typedef struct packed {
    logic timer_a_count_capture_in;
    logic timer_b_count_capture_in;
    logic timer_a_capture_in;
    logic timer_b_capture_in;
    logic timer8_a_count_in;
  } pmx_tmr_in_t;

  // Serial inputs taken from the pins
  typedef struct packed {
    logic csia_serial_in;
    logic csia_serial_clk;
    logic csib_serial_in;
    logic csib_serial_clk;
    logic csib_chip_select;
    logic uart_a_rx;
    logic uart_b_rx;
  } pmx_ser_in_t;

  // Per-bit mode select: alternate value in control mode, latch in port mode
  function automatic logic [7:0] pmx_sel(input logic [7:0] ctrl, input logic [7:0] port_v,
                                         input logic [7:0] alt_v);
    pmx_sel = (ctrl & alt_v) | (~ctrl & port_v);
  endfunction : pmx_sel

endpackage : pmx_pkg

// *** pmx_edge_det.sv ***
/*
  Edge detector for the external interrupt pin.
  Assumes sig_in is already synchronised to mclk.
*/
`timescale 1ns/1ps
module pmx_edge_det (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sig_in,
  input wire logic enable,
  input wire pmx_pkg::pmx_edge_t mode,
  output logic pulse_r
);
  import pmx_pkg::*;

  logic prev_r; // Last sampled level
  // Fills with ones once the synchroniser and prev_r hold real pin levels
  logic [2:0] arm_r;
  wire rise_w = sig_in & ~prev_r; // Rising edge seen
  wire fall_w = ~sig_in & prev_r; // Falling edge seen
  // Masked until armed: the synchroniser leaves reset at zero, not at the pin level
  wire hit_w = enable & arm_r[2] & (((mode == PMX_EDGE_RISE) | (mode == PMX_EDGE_BOTH)) & rise_w
                       | ((mode == PMX_EDGE_FALL) | (mode == PMX_EDGE_BOTH)) & fall_w);

  // Track the level and emit a one-cycle request per selected edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_r <= 1'b0;
      arm_r <= 3'h0;
      pulse_r <= 1'b0;
    end else begin
      prev_r <= sig_in;
      arm_r <= {arm_r[1:0], 1'b1}; // Avoids a false edge just after reset
      pulse_r <= hit_w;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_EDGE_RISE: assert property (enable && arm_r[2] && mode == PMX_EDGE_RISE
    && $rose(sig_in) |=> pulse_r) else $error("rising edge not reported");
  AST_EDGE_FALL: assert property (enable && mode == PMX_EDGE_FALL && $rose(sig_in)
    |=> !pulse_r) else $error("rising edge reported in falling mode");
  AST_EDGE_BOTH: assert property (enable && arm_r[2] && mode == PMX_EDGE_BOTH
    && $fell(sig_in) |=> pulse_r) else $error("falling edge missed in both mode");

endmodule : pmx_edge_det

// *** pmx_port_mux.sv ***
/*
  Pin multiplexer for port 0 (7 bits), port 1 (8 bits) and port 2 (8 bits, analog capable).
  Assumes pins arrive asynchronously and peripherals run on mclk.
*/
// How it works
// - Port 0 seven bits, per-bit direction
// - Port 0 pull-up option per bit
// - Port 0 bits choose port or control mode
// - Port 1 eight bits, per-bit direction
// - Port 1 pull-up option per bit
// - Port 1 bits choose port or control mode
// - Interrupt pin edge rising, falling or both
// - Count-capture pins feed clock and both captures
// - Capture pins feed first capture register only
// - Serial clock pin drives or receives clock
// - Chip-select pin feeds second serial unit
// - Port 2 pins selectable as analog inputs
// - Port 2 analog mode after reset
`timescale 1ns/1ps
module pmx_port_mux (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cfg_we,
  input wire pmx_pkg::pmx_reg_t cfg_sel,
  input wire logic [pmx_pkg::CFG_W-1:0] cfg_wdata,
  input wire pmx_pkg::pmx_per_out_t per_out,
  output pmx_pkg::pmx_tmr_in_t tmr_in_r,
  output pmx_pkg::pmx_ser_in_t ser_in_r,
  output logic ext_irq_req_r,
  input wire logic [pmx_pkg::P0_W-1:0] pin0_in,
  output logic [pmx_pkg::P0_W-1:0] pin0_out_r,
  output logic [pmx_pkg::P0_W-1:0] pin0_oe_r,
  output logic [pmx_pkg::P0_W-1:0] pin0_pull_r,
  input wire logic [pmx_pkg::P1_W-1:0] pin1_in,
  output logic [pmx_pkg::P1_W-1:0] pin1_out_r,
  output logic [pmx_pkg::P1_W-1:0] pin1_oe_r,
  output logic [pmx_pkg::P1_W-1:0] pin1_pull_r,
  input wire logic [pmx_pkg::P2_W-1:0] pin2_in,
  output logic [pmx_pkg::P2_W-1:0] pin2_out_r,
  output logic [pmx_pkg::P2_W-1:0] pin2_oe_r,
  output logic [pmx_pkg::P2_W-1:0] analog_inputs_r,
  output logic [pmx_pkg::P0_W-1:0] port0_rd_r,
  output logic [pmx_pkg::P1_W-1:0] port1_rd_r,
  output logic [pmx_pkg::P2_W-1:0] port2_rd_r
);
  import pmx_pkg::*;

  // Configuration registers (direction: 1 = input)
  logic [P0_W-1:0] port0_direction_reg_r;
  logic [P0_W-1:0] port0_pullup_reg_r;
  logic [P0_W-1:0] p0_ctrl_r; // 1 = control mode
  logic [P0_W-1:0] p0_latch_r; // Output latch
  logic [P1_W-1:0] port1_direction_reg_r;
  logic [P1_W-1:0] port1_pullup_reg_r;
  logic [P1_W-1:0] p1_ctrl_r;
  logic [P1_W-1:0] p1_latch_r;
  logic [P2_W-1:0] p2_dir_r;
  logic [P2_W-1:0] p2_ana_r; // 1 = analog input
  logic [P2_W-1:0] p2_latch_r;
  pmx_edge_t irq_edge_r; // Active interrupt edge

  // Two-stage synchronisers; stage one is read by stage two only
  logic [P0_W-1:0] p0_s1_r, p0_s2_r;
  logic [P1_W-1:0] p1_s1_r, p1_s2_r;
  logic [P2_W-1:0] p2_s1_r, p2_s2_r;

  // Write strobes per register
  wire wr_p0_dir = cfg_we & (cfg_sel == PMX_REG_P0_DIR);
  wire wr_p0_pull = cfg_we & (cfg_sel == PMX_REG_P0_PULL);
  wire wr_p0_ctrl = cfg_we & (cfg_sel == PMX_REG_P0_CTRL);
  wire wr_p0_out = cfg_we & (cfg_sel == PMX_REG_P0_OUT);
  wire wr_p1_dir = cfg_we & (cfg_sel == PMX_REG_P1_DIR);
  wire wr_p1_pull = cfg_we & (cfg_sel == PMX_REG_P1_PULL);
  wire wr_p1_ctrl = cfg_we & (cfg_sel == PMX_REG_P1_CTRL);
  wire wr_p1_out = cfg_we & (cfg_sel == PMX_REG_P1_OUT);
  wire wr_p2_dir = cfg_we & (cfg_sel == PMX_REG_P2_DIR);
  wire wr_p2_ana = cfg_we & (cfg_sel == PMX_REG_P2_ANA);
  wire wr_p2_out = cfg_we & (cfg_sel == PMX_REG_P2_OUT);
  wire wr_edge = cfg_we & (cfg_sel == PMX_REG_IRQ_EDGE);

  // Alternate output values; input-only functions contribute zero
  wire [7:0] p0_alt_w = {1'b0, per_out.timer_b_out, 1'b0, per_out.csib_serial_clk, 1'b0,
                         per_out.csib_serial_out, per_out.timer_a_out, 1'b0};
  // Clock and UART transmit share a pin; both idle high, so they are ANDed
  wire [7:0] p1_alt_w = {per_out.timer8_a_out, per_out.timer8h_b_out, per_out.timer8h_a_out,
                         1'b0, per_out.uart_b_tx, per_out.csia_serial_out, 1'b0,
                         per_out.csia_serial_clk & per_out.uart_a_tx};

  // Pin drive and pull-up decoding
  wire [7:0] p0_out_nxt = pmx_sel({1'b0, p0_ctrl_r}, {1'b0, p0_latch_r}, p0_alt_w);
  wire [7:0] p1_out_nxt = pmx_sel(p1_ctrl_r, p1_latch_r, p1_alt_w);
  wire [P0_W-1:0] p0_oe_nxt = ~port0_direction_reg_r;
  wire [P1_W-1:0] p1_oe_nxt = ~port1_direction_reg_r;
  wire [P0_W-1:0] p0_pull_nxt = port0_pullup_reg_r & port0_direction_reg_r;
  wire [P1_W-1:0] p1_pull_nxt = port1_pullup_reg_r & port1_direction_reg_r;
  wire [P2_W-1:0] p2_oe_nxt = ~p2_dir_r & ~p2_ana_r;

  // Pin inputs usable by a peripheral: control mode and input direction
  wire [P0_W-1:0] p0_take_w = p0_ctrl_r & port0_direction_reg_r;
  wire [P1_W-1:0] p1_take_w = p1_ctrl_r & port1_direction_reg_r;

  // Peripheral input decoding; idle-high lines rest at one when not selected
  pmx_tmr_in_t tmr_nxt;
  pmx_ser_in_t ser_nxt;
  assign tmr_nxt.timer_a_count_capture_in = p0_take_w[P0_TA_CC] & p0_s2_r[P0_TA_CC];
  assign tmr_nxt.timer_b_count_capture_in = p0_take_w[P0_TB_CC] & p0_s2_r[P0_TB_CC];
  assign tmr_nxt.timer_a_capture_in = p0_take_w[P0_TA_CAP] & p0_s2_r[P0_TA_CAP];
  assign tmr_nxt.timer_b_capture_in = p0_take_w[P0_TB_CAP] & p0_s2_r[P0_TB_CAP];
  assign tmr_nxt.timer8_a_count_in = p1_take_w[P1_T8_A] & p1_s2_r[P1_T8_A];
  assign ser_nxt.csib_serial_in = p0_take_w[P0_CSB_SI] & p0_s2_r[P0_CSB_SI];
  assign ser_nxt.csib_serial_clk = ~p0_take_w[P0_CSB_CLK] | p0_s2_r[P0_CSB_CLK];
  assign ser_nxt.csib_chip_select = ~p0_take_w[P0_TB_CC] | p0_s2_r[P0_TB_CC];
  assign ser_nxt.csia_serial_clk = ~p1_take_w[P1_CSA_CLK] | p1_s2_r[P1_CSA_CLK];
  assign ser_nxt.csia_serial_in = p1_take_w[P1_CSA_SI] & p1_s2_r[P1_CSA_SI];
  assign ser_nxt.uart_a_rx = ~p1_take_w[P1_CSA_SI] | p1_s2_r[P1_CSA_SI];
  assign ser_nxt.uart_b_rx = ~p1_take_w[P1_UB_RX] | p1_s2_r[P1_UB_RX];

  // Interrupt edge detection on the port 1 interrupt pin
  pmx_edge_det u_edge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sig_in(p1_s2_r[P1_IRQ]),
    .enable(p1_take_w[P1_IRQ]),
    .mode(irq_edge_r),
    .pulse_r(ext_irq_req_r)
  );

  // Port 0 configuration registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      port0_direction_reg_r <= P0_DIR_RST;
      port0_pullup_reg_r <= P0_ZERO;
      p0_ctrl_r <= P0_ZERO;
      p0_latch_r <= P0_ZERO;
    end else begin
      if (wr_p0_dir) port0_direction_reg_r <= cfg_wdata[P0_W-1:0];
      if (wr_p0_pull) port0_pullup_reg_r <= cfg_wdata[P0_W-1:0];
      if (wr_p0_ctrl) p0_ctrl_r <= cfg_wdata[P0_W-1:0];
      if (wr_p0_out) p0_latch_r <= cfg_wdata[P0_W-1:0];
    end
  end

  // Port 1 configuration registers and interrupt edge select
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      port1_direction_reg_r <= P1_DIR_RST;
      port1_pullup_reg_r <= P1_ZERO;
      p1_ctrl_r <= P1_ZERO;
      p1_latch_r <= P1_ZERO;
      irq_edge_r <= PMX_EDGE_NONE;
    end else begin
      if (wr_p1_dir) port1_direction_reg_r <= cfg_wdata;
      if (wr_p1_pull) port1_pullup_reg_r <= cfg_wdata;
      if (wr_p1_ctrl) p1_ctrl_r <= cfg_wdata;
      if (wr_p1_out) p1_latch_r <= cfg_wdata;
      if (wr_edge) irq_edge_r <= pmx_edge_t'(cfg_wdata[1:0]);
    end
  end

  // Port 2 configuration registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      p2_dir_r <= P2_DIR_RST;
      p2_ana_r <= P2_ANA_RST;
      p2_latch_r <= P2_ZERO;
    end else begin
      if (wr_p2_dir) p2_dir_r <= cfg_wdata;
      if (wr_p2_ana) p2_ana_r <= cfg_wdata;
      if (wr_p2_out) p2_latch_r <= cfg_wdata;
    end
  end

  // Input synchronisers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {p0_s1_r, p0_s2_r} <= {P0_ZERO, P0_ZERO};
      {p1_s1_r, p1_s2_r} <= {P1_ZERO, P1_ZERO};
      {p2_s1_r, p2_s2_r} <= {P2_ZERO, P2_ZERO};
    end else begin
      {p0_s1_r, p0_s2_r} <= {pin0_in, p0_s1_r};
      {p1_s1_r, p1_s2_r} <= {pin1_in, p1_s1_r};
      {p2_s1_r, p2_s2_r} <= {pin2_in, p2_s1_r};
    end
  end

  // Registered pin drives, peripheral inputs and read-back
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin0_out_r <= P0_ZERO;
      pin0_oe_r <= P0_ZERO;
      pin0_pull_r <= P0_ZERO;
      pin1_out_r <= P1_ZERO;
      pin1_oe_r <= P1_ZERO;
      pin1_pull_r <= P1_ZERO;
      pin2_out_r <= P2_ZERO;
      pin2_oe_r <= P2_ZERO;
      analog_inputs_r <= P2_ANA_RST;
      tmr_in_r <= '0;
      ser_in_r <= '1;
      port0_rd_r <= P0_ZERO;
      port1_rd_r <= P1_ZERO;
      port2_rd_r <= P2_ZERO;
    end else begin
      pin0_out_r <= p0_out_nxt[P0_W-1:0];
      pin0_oe_r <= p0_oe_nxt;
      pin0_pull_r <= p0_pull_nxt;
      pin1_out_r <= p1_out_nxt;
      pin1_oe_r <= p1_oe_nxt;
      pin1_pull_r <= p1_pull_nxt;
      pin2_out_r <= p2_latch_r;
      pin2_oe_r <= p2_oe_nxt;
      analog_inputs_r <= p2_ana_r;
      tmr_in_r <= tmr_nxt;
      ser_in_r <= ser_nxt;
      port0_rd_r <= p0_s2_r;
      port1_rd_r <= p1_s2_r;
      port2_rd_r <= p2_s2_r & ~p2_ana_r; // Analog pins read as zero
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_P0_DIR: assert property (pin0_oe_r == ~$past(port0_direction_reg_r))
    else $error("port 0 drive does not follow direction");
  AST_P0_PULL: assert property (pin0_oe_r[P0_TA_CC] |-> !pin0_pull_r[P0_TA_CC])
    else $error("port 0 pull-up active while driving");
  AST_P0_CTRL: assert property ((pin0_out_r & ~$past(p0_ctrl_r))
    == ($past(p0_latch_r) & ~$past(p0_ctrl_r)))
    else $error("port 0 port-mode bit not from latch");
  AST_P1_DIR: assert property (wr_p1_dir |=> ##1 pin1_oe_r == ~$past(cfg_wdata, 2))
    else $error("port 1 direction write not applied");
  AST_P1_PULL: assert property (pin1_pull_r == $past(port1_pullup_reg_r
    & port1_direction_reg_r))
    else $error("port 1 pull-up wrong");
  AST_P1_CTRL: assert property (p1_ctrl_r[P1_T8H_A] && !port1_direction_reg_r[P1_T8H_A]
    |=> pin1_out_r[P1_T8H_A] == $past(per_out.timer8h_a_out))
    else $error("port 1 control output not from timer");
  // Pin level sampled at edge k reaches the timer input at edge k+2, seen at k+3
  AST_TMR_CC: assert property (p0_take_w[P0_TA_CC] && $past(p0_take_w[P0_TA_CC])
    |=> tmr_in_r.timer_a_count_capture_in == $past(pin0_in[P0_TA_CC], 3))
    else $error("count-capture input latency wrong");
  AST_TMR_CAP: assert property (!p0_ctrl_r[P0_TB_CAP]
    |=> !tmr_in_r.timer_b_capture_in)
    else $error("capture input leaks in port mode");
  AST_CLK_DRV: assert property (p0_ctrl_r[P0_CSB_CLK] && !port0_direction_reg_r[P0_CSB_CLK]
    |=> pin0_oe_r[P0_CSB_CLK] && pin0_out_r[P0_CSB_CLK] == $past(per_out.csib_serial_clk))
    else $error("serial clock not driven as master");
  AST_CS: assert property (!p0_take_w[P0_TB_CC] |=> ser_in_r.csib_chip_select)
    else $error("chip select not idle when unselected");
  AST_P2_ANA: assert property (p2_ana_r != P2_ZERO
    |=> (pin2_oe_r & analog_inputs_r) == P2_ZERO)
    else $error("analog pin driven");
  AST_P2_RST: assert property ($past(sys_rst) |-> analog_inputs_r == P2_ANA_RST)
    else $error("port 2 not analog after reset");
  AST_PORT_RST: assert property ($past(sys_rst) |-> pin0_oe_r == P0_ZERO
    && pin1_pull_r == P1_ZERO && p1_ctrl_r == P1_ZERO)
    else $error("ports not input port mode after reset");

  COV_IRQ: cover property (ext_irq_req_r);
  COV_CLK_SLAVE: cover property (p0_take_w[P0_CSB_CLK] ##1 !ser_in_r.csib_serial_clk);
  COV_P2_DIGITAL: cover property (pin2_oe_r != P2_ZERO);

endmodule : pmx_port_mux

// *** pmx_periph_model.sv ***
/*
  Behavioural model of the on-chip timers and serial units that feed the multiplexer.
  Assumes the testbench supplies the wanted output levels and that all runs on mclk.
*/
`timescale 1ns/1ps
module pmx_periph_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire pmx_pkg::pmx_per_out_t level_set,
  output pmx_pkg::pmx_per_out_t per_out
);
  import pmx_pkg::*;

  // Peripheral outputs change on the clock like real timer and shift logic
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      // Idle levels: serial clocks and transmit lines rest high
      per_out <= '{csia_serial_clk: 1'b1, csib_serial_clk: 1'b1, uart_a_tx: 1'b1,
                   uart_b_tx: 1'b1, default: 1'b0};
    end else begin
      per_out <= level_set;
    end
  end
endmodule : pmx_periph_model

// *** pmx_port_mux_test.sv ***
/*
  Self-checking testbench for the port 0 / port 1 / port 2 pin multiplexer.
  Assumes the peripheral model drives per_out and the bench drives pins and config.
*/
`timescale 1ns/1ps
module pmx_port_mux_test;
  import pmx_pkg::*;

  logic mclk;
  logic sys_rst;
  logic cfg_we;
  pmx_reg_t cfg_sel;
  logic [CFG_W-1:0] cfg_wdata;
  pmx_per_out_t level_set;
  pmx_per_out_t per_out;
  pmx_tmr_in_t tmr_in_r;
  pmx_ser_in_t ser_in_r;
  logic ext_irq_req_r;
  logic [P0_W-1:0] pin0_in, pin0_out_r, pin0_oe_r, pin0_pull_r, port0_rd_r;
  logic [P1_W-1:0] pin1_in, pin1_out_r, pin1_oe_r, pin1_pull_r, port1_rd_r;
  logic [P2_W-1:0] pin2_in, pin2_out_r, pin2_oe_r, analog_inputs_r, port2_rd_r;
  int error_cnt = 0;
  int n_tests = 0;
  int cnt;

  // Far-side peripherals
  pmx_periph_model model (.mclk(mclk), .sys_rst(sys_rst), .level_set(level_set),
    .per_out(per_out));

  pmx_port_mux dut (.mclk(mclk), .sys_rst(sys_rst), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
    .cfg_wdata(cfg_wdata), .per_out(per_out), .tmr_in_r(tmr_in_r), .ser_in_r(ser_in_r),
    .ext_irq_req_r(ext_irq_req_r), .pin0_in(pin0_in), .pin0_out_r(pin0_out_r),
    .pin0_oe_r(pin0_oe_r), .pin0_pull_r(pin0_pull_r), .pin1_in(pin1_in),
    .pin1_out_r(pin1_out_r), .pin1_oe_r(pin1_oe_r), .pin1_pull_r(pin1_pull_r),
    .pin2_in(pin2_in), .pin2_out_r(pin2_out_r), .pin2_oe_r(pin2_oe_r),
    .analog_inputs_r(analog_inputs_r), .port0_rd_r(port0_rd_r), .port1_rd_r(port1_rd_r),
    .port2_rd_r(port2_rd_r));

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Advance n edges, then move 1 ns off the edge
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  // One-cycle write strobe; returns once the new value has reached the pins
  task wr(input pmx_reg_t sel, input logic [7:0] data);
    cfg_we = 1'b1;
    cfg_sel = sel;
    cfg_wdata = data;
    step(1);
    cfg_we = 1'b0;
    step(1);
  endtask : wr

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Count interrupt pulses over eight edges
  task pulses(output int c);
    c = 0;
    repeat (8) begin
      step(1);
      if (ext_irq_req_r === 1'b1) c++;
    end
  endtask : pulses

  // Verdict and end of run
  task conclude;
    $display("tests=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Reset defaults on every pin group
  task reset_check;
    chk(pin0_oe_r, 0);
    chk(pin0_pull_r, 0);
    chk(pin1_oe_r, 0);
    chk(pin1_pull_r, 0);
    chk(tmr_in_r, 0);
    // Data inputs rest low, clocks, chip select and receive lines rest high
    chk(ser_in_r, 7'h2F);
    chk(analog_inputs_r, 8'hFF);
  endtask : reset_check

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    cfg_we = 1'b0;
    cfg_sel = PMX_REG_P0_DIR;
    cfg_wdata = 8'h00;
    level_set = '0;
    pin0_in = 7'h00;
    pin1_in = 8'hFF;
    pin2_in = 8'hFF;
    step(8);
    sys_rst = 1'b0;
    step(1);
    reset_check();
    $display("test reset done");
    // Direction and data in port mode; bit 7 of the port 0 write is dropped
    wr(PMX_REG_P0_OUT, 8'hFF);
    wr(PMX_REG_P0_DIR, 8'h7E);
    chk(pin0_oe_r, 7'h01);
    chk(pin0_out_r[0], 1'b1);
    wr(PMX_REG_P1_DIR, 8'h5A);
    chk(pin1_oe_r, 8'hA5);
    // Unlisted select code is ignored
    wr(pmx_reg_t'(4'hC), 8'h00);
    chk(pin1_oe_r, 8'hA5);
    // Pull-ups only on input bits
    wr(PMX_REG_P0_DIR, 8'h7D);
    wr(PMX_REG_P0_PULL, 8'h2B);
    chk(pin0_pull_r, 7'h29);
    wr(PMX_REG_P1_DIR, 8'h0F);
    wr(PMX_REG_P1_PULL, 8'hFF);
    chk(pin1_pull_r, 8'h0F);
    // Port mode keeps timer inputs at rest even when pins move
    pin0_in = 7'h7F;
    step(4);
    chk(tmr_in_r, 0);
    chk(port0_rd_r, 7'h7F);
    $display("test port mode done");
    // Control mode inputs on port 0, two patterns
    wr(PMX_REG_P0_DIR, 8'h7F);
    wr(PMX_REG_P0_CTRL, 8'h7F);
    for (int k = 0; k < 2; k++) begin
      pin0_in = k ? 7'h21 : 7'h5E;
      step(4);
      chk(tmr_in_r.timer_a_count_capture_in, pin0_in[0]);
      chk(tmr_in_r.timer_b_count_capture_in, pin0_in[5]);
      chk(tmr_in_r.timer_a_capture_in, pin0_in[1]);
      chk(tmr_in_r.timer_b_capture_in, pin0_in[6]);
      chk(ser_in_r.csib_chip_select, pin0_in[5]);
      chk(ser_in_r.csib_serial_in, pin0_in[3]);
      chk(ser_in_r.csib_serial_clk, pin0_in[4]);
    end
    // Control mode outputs: serial clock driven as master
    wr(PMX_REG_P0_DIR, 8'h29);
    wr(PMX_REG_P1_DIR, 8'h52);
    wr(PMX_REG_P1_CTRL, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      level_set = k ? 11'h555 : 11'h2AA;
      step(3);
      chk(pin0_oe_r, 7'h56);
      chk(pin0_out_r[1], level_set.timer_a_out);
      chk(pin0_out_r[2], level_set.csib_serial_out);
      chk(pin0_out_r[4], level_set.csib_serial_clk);
      chk(pin0_out_r[6], level_set.timer_b_out);
      chk(pin1_out_r[0], level_set.csia_serial_clk & level_set.uart_a_tx);
      chk(pin1_out_r[2], level_set.csia_serial_out);
      chk(pin1_out_r[3], level_set.uart_b_tx);
      chk(pin1_out_r[5], level_set.timer8h_a_out);
      chk(pin1_out_r[7], level_set.timer8_a_out);
    end
    // Control mode inputs on port 1
    pin1_in = 8'hAD;
    step(4);
    chk(ser_in_r.csia_serial_in, 1'b0);
    chk(ser_in_r.uart_a_rx, 1'b0);
    chk(ser_in_r.uart_b_rx, 1'b0);
    chk(port1_rd_r, 8'hAD);
    $display("test control mode done");
    // Every edge code: rising and falling pin edges
    for (int e = 0; e < 4; e++) begin
      pin1_in[6] = 1'b0;
      step(6);
      wr(PMX_REG_IRQ_EDGE, 8'(e));
      pin1_in[6] = 1'b1;
      pulses(cnt);
      chk(cnt, e & 1);
      pin1_in[6] = 1'b0;
      pulses(cnt);
      chk(cnt, e >> 1);
    end
    $display("test interrupt done");
    // Port 2 analog selection forces the digital side off
    wr(PMX_REG_P2_ANA, 8'h0F);
    wr(PMX_REG_P2_DIR, 8'h00);
    wr(PMX_REG_P2_OUT, 8'h5A);
    step(3);
    chk(analog_inputs_r, 8'h0F);
    chk(pin2_oe_r, 8'hF0);
    chk(pin2_out_r, 8'h5A);
    // Pins are all high; only the analog bits read as zero
    chk(port2_rd_r, 8'hF0);
    $display("test port 2 done");
    // Reset in mid-run returns every default
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    step(1);
    reset_check();
    $display("test second reset done");
    conclude();
  end
endmodule : pmx_port_mux_test
